// ---- src/timer0_prescaler_regs.sv ----
// eight-bit timer with shared timer/watchdog prescaler behind an apb slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module timer0_prescaler_regs (
	input  wire logic                        clk_sys,
	input  wire logic                        arst_n,
	input  wire logic                        por_n,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [tmr_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        timer_clk_pin,
	input  wire logic                        ext_irq_pin,
	input  wire logic                        port_change_pin,
	input  wire logic                        watchdog_osc_tick,
	output logic                             watchdog_tick,
	output logic                             pullup_disable,
	output logic                             cpu_irq,
	output logic                             irq
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [tmr_pkg::PIN_N-1:0] sync1_r;
	logic [tmr_pkg::PIN_N-1:0] sync2_r;
	logic [tmr_pkg::PIN_N-1:0] prev_r;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end else begin
			sync1_r <= {watchdog_osc_tick, port_change_pin, ext_irq_pin, timer_clk_pin};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	logic [tmr_pkg::PIN_N-1:0] rise;
	logic [tmr_pkg::PIN_N-1:0] fall;
	assign rise = sync2_r & ~prev_r;
	assign fall = ~sync2_r & prev_r;

	// ************************************************************
	// apb decode
	// ************************************************************
	tmr_pkg::option_s opt_r;
	tmr_pkg::option_s opt_nxt;
	tmr_pkg::ictl_s   ictl_r;
	tmr_pkg::ictl_s   ictl_nxt;
	logic             port_flag_r;
	logic             port_flag_nxt;
	logic [7:0]       count_r;
	logic [7:0]       count_nxt;
	logic [tmr_pkg::EV_N-1:0] evt_stat_r;
	logic [tmr_pkg::EV_N-1:0] evt_stat_nxt;
	logic [tmr_pkg::EV_N-1:0] evt_mask_r;
	logic [tmr_pkg::EV_N-1:0] evt_mask_nxt;
	logic [31:0]      prdata_r;
	logic [31:0]      prdata_nxt;

	logic [8:0] idx;
	logic       hit_count;
	logic       hit_ictl;
	logic       hit_opt;
	logic       hit_stat;
	logic       hit_mask;
	logic       wr;

	assign idx = paddr[10:2];
	// upper and lane bits must be zero, otherwise the access lands nowhere
	assign wr  = psel && penable && pwrite && (paddr[11] == 1'b0) && (paddr[1:0] == 2'b00);

	always_comb begin
		hit_count = (idx == tmr_pkg::IDX_COUNT_A) || (idx == tmr_pkg::IDX_COUNT_B);
		hit_ictl  = (idx == tmr_pkg::IDX_ICTL_A) || (idx == tmr_pkg::IDX_ICTL_B)
		         || (idx == tmr_pkg::IDX_ICTL_C) || (idx == tmr_pkg::IDX_ICTL_D);
		hit_opt   = (idx == tmr_pkg::IDX_OPT_A) || (idx == tmr_pkg::IDX_OPT_B);
		hit_stat  = (idx == tmr_pkg::IDX_EVT_STAT);
		hit_mask  = (idx == tmr_pkg::IDX_EVT_MASK);
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_comb begin
		prdata_nxt = prdata_r;
		if (psel && !penable && !pwrite) begin
			prdata_nxt = 32'h0000_0000;
			if ((paddr[11] == 1'b0) && (paddr[1:0] == 2'b00)) begin
				if (hit_count) begin
					prdata_nxt[7:0] = count_r;
				end else if (hit_ictl) begin
					prdata_nxt[7:0] = {ictl_r[7:1], port_flag_r};
				end else if (hit_opt) begin
					prdata_nxt[7:0] = opt_r;
				end else if (hit_stat) begin
					prdata_nxt[tmr_pkg::EV_N-1:0] = evt_stat_r;
				end else if (hit_mask) begin
					prdata_nxt[tmr_pkg::EV_N-1:0] = evt_mask_r;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			prdata_r <= 32'h0000_0000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// ************************************************************
	// count source and prescaler
	// ************************************************************
	logic src_tick;
	logic pre_tick;
	logic pre_pulse;
	logic pre_clear;
	logic timer_inc;
	logic [3:0] exponent;

	always_comb begin
		if (opt_r.clock_source_select) begin
			src_tick = opt_r.source_edge_select ? fall[tmr_pkg::PIN_TCLK]
			                                    : rise[tmr_pkg::PIN_TCLK];
		end else begin
			src_tick = 1'b1;
		end
		// prescaler_assign high hands the divider to the watchdog
		pre_tick = opt_r.prescaler_assign ? rise[tmr_pkg::PIN_WDOG] : src_tick;
		// timer gets one extra halving at each code
		exponent = {1'b0, opt_r.rate} + (opt_r.prescaler_assign ? 4'h0 : 4'h1);
		// an assignment change, or a count write while the divider belongs to the timer (prescaler_assign low), restarts the divider
		pre_clear = (wr && hit_opt && (pwdata[3] != opt_r.prescaler_assign))
		         || (wr && hit_count && !opt_r.prescaler_assign);
		timer_inc = opt_r.prescaler_assign ? src_tick : pre_pulse;
		watchdog_tick = opt_r.prescaler_assign ? pre_pulse : rise[tmr_pkg::PIN_WDOG];
	end

	prescale_div u_div (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.tick     (pre_tick),
		.clear    (pre_clear),
		.exponent (exponent),
		.pulse    (pre_pulse)
	);

	// ************************************************************
	// events
	// ************************************************************
	logic [tmr_pkg::EV_N-1:0] ev;
	logic                     ovf;

	always_comb begin
		ovf                  = timer_inc && (count_r == 8'hff) && !(wr && hit_count);
		ev                   = '0;
		ev[tmr_pkg::EV_OVF]  = ovf;
		ev[tmr_pkg::EV_EXT]  = opt_r.irq_edge_select ? rise[tmr_pkg::PIN_EXT]
		                                             : fall[tmr_pkg::PIN_EXT];
		ev[tmr_pkg::EV_PORT] = rise[tmr_pkg::PIN_PORT] | fall[tmr_pkg::PIN_PORT];
	end

	// ************************************************************
	// timer count, kept across ordinary resets
	// ************************************************************
	always_comb begin
		count_nxt = count_r;
		if (wr && hit_count) begin
			count_nxt = pwdata[7:0];
		end else if (timer_inc) begin
			count_nxt = count_r + 8'h01;
		end
	end

	// only power-on clears it; unknown on power-up is made a defined zero
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			count_r <= tmr_pkg::COUNT_POR;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ************************************************************
	// port change flag, kept across ordinary resets
	// ************************************************************
	always_comb begin
		port_flag_nxt = port_flag_r;
		if (wr && hit_ictl) begin
			port_flag_nxt = pwdata[0];
		end
		// set beats a software clear in the same cycle
		port_flag_nxt = port_flag_nxt | ev[tmr_pkg::EV_PORT];
	end

	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			port_flag_r <= 1'b0;
		end else begin
			port_flag_r <= port_flag_nxt;
		end
	end

	// ************************************************************
	// interrupt control and option
	// ************************************************************
	always_comb begin
		ictl_nxt = ictl_r;
		opt_nxt  = opt_r;
		if (wr && hit_ictl) begin
			ictl_nxt = tmr_pkg::ictl_s'(pwdata[7:0]);
		end
		if (wr && hit_opt) begin
			opt_nxt = tmr_pkg::option_s'(pwdata[7:0]);
		end
		ictl_nxt.overflow_flag     = ictl_nxt.overflow_flag | ev[tmr_pkg::EV_OVF];
		ictl_nxt.external_irq_flag = ictl_nxt.external_irq_flag | ev[tmr_pkg::EV_EXT];
		ictl_nxt.port_change_flag  = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ictl_r <= tmr_pkg::ictl_s'(tmr_pkg::ICTL_RST);
			opt_r  <= tmr_pkg::option_s'(tmr_pkg::OPT_RST);
		end else begin
			ictl_r <= ictl_nxt;
			opt_r  <= opt_nxt;
		end
	end

	// ************************************************************
	// sticky status, mask, interrupt outputs
	// ************************************************************
	always_comb begin
		evt_stat_nxt = evt_stat_r;
		evt_mask_nxt = evt_mask_r;
		if (wr && hit_stat) begin
			evt_stat_nxt = evt_stat_r & ~pwdata[tmr_pkg::EV_N-1:0];
		end
		if (wr && hit_mask) begin
			evt_mask_nxt = pwdata[tmr_pkg::EV_N-1:0];
		end
		evt_stat_nxt = evt_stat_nxt | ev;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			evt_stat_r <= tmr_pkg::EVT_RST;
			evt_mask_r <= tmr_pkg::EVT_RST;
		end else begin
			evt_stat_r <= evt_stat_nxt;
			evt_mask_r <= evt_mask_nxt;
		end
	end

	assign irq            = |(evt_stat_r & evt_mask_r);
	// no peripherals behind this block, so the peripheral enable gates nothing here
	assign cpu_irq        = ictl_r.global_irq_enable
	                     && ((ictl_r.overflow_irq_enable && ictl_r.overflow_flag)
	                      || (ictl_r.external_irq_enable && ictl_r.external_irq_flag)
	                      || (ictl_r.port_change_irq_enable && port_flag_r));
	assign pullup_disable = opt_r.pullup_disable;
endmodule

// ---- src/tmr_pkg.sv ----
// shared constants and carrier types for the timer/prescaler register block
package tmr_pkg;

	// register indexes; byte address is four times the index
	localparam logic [8:0] IDX_COUNT_A  = 9'h001;
	localparam logic [8:0] IDX_COUNT_B  = 9'h101;
	localparam logic [8:0] IDX_ICTL_A   = 9'h00b;
	localparam logic [8:0] IDX_ICTL_B   = 9'h08b;
	localparam logic [8:0] IDX_ICTL_C   = 9'h10b;
	localparam logic [8:0] IDX_ICTL_D   = 9'h18b;
	localparam logic [8:0] IDX_OPT_A    = 9'h081;
	localparam logic [8:0] IDX_OPT_B    = 9'h181;
	localparam logic [8:0] IDX_EVT_STAT = 9'h1f0;
	localparam logic [8:0] IDX_EVT_MASK = 9'h1f1;

	localparam int ADDR_W = 12;

	// reset values
	localparam logic [7:0] COUNT_POR    = 8'h00;
	localparam logic [7:0] ICTL_RST     = 8'h00;
	localparam logic [7:0] OPT_RST      = 8'hff;
	localparam logic [2:0] EVT_RST      = 3'h0;

	// event bit positions in status, mask and the low flags of interrupt_control
	localparam int EV_PORT  = 0;
	localparam int EV_EXT   = 1;
	localparam int EV_OVF   = 2;
	localparam int EV_N     = 3;

	// synchronised pin positions
	localparam int PIN_TCLK = 0;
	localparam int PIN_EXT  = 1;
	localparam int PIN_PORT = 2;
	localparam int PIN_WDOG = 3;
	localparam int PIN_N    = 4;

	typedef struct packed {
		logic       pullup_disable;
		logic       irq_edge_select;
		logic       clock_source_select;
		logic       source_edge_select;
		logic       prescaler_assign;
		logic [2:0] rate;
	} option_s;

	typedef struct packed {
		logic global_irq_enable;
		logic peripheral_irq_enable;
		logic overflow_irq_enable;
		logic external_irq_enable;
		logic port_change_irq_enable;
		logic overflow_flag;
		logic external_irq_flag;
		logic port_change_flag;
	} ictl_s;

endpackage

// ---- src/prescale_div.sv ----
// shared power-of-two prescaler counter
`timescale 1ns/1ps
module prescale_div (
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic [3:0] exponent,
	output logic            pulse
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [8:0] mask;

	// exponent 0 passes every tick, 8 divides by 256
	always_comb begin
		mask    = (9'h001 << exponent) - 9'h001;
		pulse   = tick && ((cnt_r & mask[7:0]) == mask[7:0]);
		cnt_nxt = cnt_r;
		if (clear) begin
			cnt_nxt = 8'h00;
		end else if (tick) begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// ---- sim/timer0_prescaler_regs_chk.sv ----
// checker for the apb side and watchdog pins of the timer/prescaler register block
`timescale 1ns/1ps
module timer0_prescaler_regs_chk (
	input wire logic                       clk_sys,
	input wire logic                       arst_n,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic                       watchdog_osc_tick,
	input wire logic                       watchdog_tick,
	input wire logic                       pullup_disable,
	input wire logic                       cpu_irq,
	input wire logic                       irq
);
	localparam logic [tmr_pkg::ADDR_W-1:0] OPT_A = {1'b0, tmr_pkg::IDX_OPT_A, 2'b00};
	localparam logic [tmr_pkg::ADDR_W-1:0] OPT_B = {1'b0, tmr_pkg::IDX_OPT_B, 2'b00};
	logic [2:0] since_rise_r;
	logic [2:0] since_rise_nxt;
	logic       osc_d_r;

	// saturating age of the last raw oscillator rise; sync delay is 2-3 cycles
	always_comb begin
		since_rise_nxt = (since_rise_r == 3'h7) ? 3'h7 : since_rise_r + 3'h1;
		if (watchdog_osc_tick && !osc_d_r) begin
			since_rise_nxt = 3'h0;
		end
	end
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			since_rise_r <= 3'h7;
			osc_d_r <= 1'b0;
		end else begin
			since_rise_r <= since_rise_nxt;
			osc_d_r <= watchdog_osc_tick;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence rd_acc;
		psel && penable && !pwrite;
	endsequence
	sequence opt_wr;
		psel && penable && pwrite && (paddr == OPT_A || paddr == OPT_B);
	endsequence

	upper_zero_a : assert property (rd_acc |-> prdata[31:8] == 24'h0)
		else $error("read data has upper bits set");
	unmapped_zero_a : assert property (rd_acc ##0 (paddr[1:0] != 2'h0 || paddr[11])
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	no_error_a : assert property (psel && penable |-> pready && !pslverr)
		else $error("access stalled or flagged an error");
	pullup_follow_a : assert property (opt_wr |=> pullup_disable == $past(pwdata[7]))
		else $error("pull-up disable does not follow option write");
	reset_state_a : assert property ($rose(arst_n) |-> pullup_disable && !irq && !cpu_irq)
		else $error("wrong output state after reset");
	tick_cause_a : assert property (watchdog_tick |-> since_rise_r <= 3'h5)
		else $error("watchdog tick without oscillator rise");
endmodule

bind timer0_prescaler_regs timer0_prescaler_regs_chk u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .watchdog_osc_tick(watchdog_osc_tick),
	.watchdog_tick(watchdog_tick), .pullup_disable(pullup_disable), .cpu_irq(cpu_irq), .irq(irq));

// ---- sim/timer0_prescaler_regs_test.sv ----
// apb test sequence for the timer/prescaler register block
`timescale 1ns/1ps
module timer0_prescaler_regs_test;
	localparam logic [8:0] CA = tmr_pkg::IDX_COUNT_A, CB = tmr_pkg::IDX_COUNT_B;
	localparam logic [8:0] IA = tmr_pkg::IDX_ICTL_A, IB = tmr_pkg::IDX_ICTL_B;
	localparam logic [8:0] IC = tmr_pkg::IDX_ICTL_C, ID = tmr_pkg::IDX_ICTL_D;
	localparam logic [8:0] OA = tmr_pkg::IDX_OPT_A, OB = tmr_pkg::IDX_OPT_B;
	localparam logic [8:0] ST = tmr_pkg::IDX_EVT_STAT, MK = tmr_pkg::IDX_EVT_MASK;
	logic                       clk_sys, arst_n, por_n, psel, penable, pwrite;
	logic                       pready, pslverr, watchdog_tick, pullup_disable, cpu_irq, irq;
	logic [tmr_pkg::ADDR_W-1:0] paddr;
	logic [31:0]                pwdata, prdata, v, w;
	logic [3:0]                 pin;
	int                         n_fail, tests_run, t0;
	// only the tick counter below writes this; scenarios take a base instead
	int                         ticks = 0;

	timer0_prescaler_regs DUT (.clk_sys(clk_sys), .arst_n(arst_n), .por_n(por_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_clk_pin(pin[tmr_pkg::PIN_TCLK]),
		.ext_irq_pin(pin[tmr_pkg::PIN_EXT]), .port_change_pin(pin[tmr_pkg::PIN_PORT]),
		.watchdog_osc_tick(pin[tmr_pkg::PIN_WDOG]), .watchdog_tick(watchdog_tick),
		.pullup_disable(pullup_disable), .cpu_irq(cpu_irq), .irq(irq));

	// ****************
	// bus and checks
	// ****************
	task automatic end_sim;
		if (n_fail == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic xfer(input logic wr_en, input logic [tmr_pkg::ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			end_sim();
		end
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] i, input logic [7:0] d);
		xfer(1'b1, {1'b0, i, 2'b00}, {24'h0, d});
	endtask
	task automatic rc(input string nm, input logic [8:0] i, input logic [7:0] e);
		xfer(1'b0, {1'b0, i, 2'b00}, 32'h0);
		chk(nm, v, {24'h0, e});
	endtask
	// pin rises spaced five cycles so the synchroniser sees each one
	task automatic rise(input int b, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			pin[b] <= 1'b1;
			repeat (2) @(posedge clk_sys);
			pin[b] <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
	endtask
	task automatic do_rst(input logic cold);
		@(posedge clk_sys);
		arst_n <= 1'b0;
		por_n <= ~cold;
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		por_n <= 1'b1;
	endtask

	always @(posedge clk_sys) if (watchdog_tick === 1'b1) ticks <= ticks + 1;
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ****************
	// scenarios
	// ****************
	initial begin
		{arst_n, por_n, psel, penable, pwrite} = 5'h0;
		paddr = '0;
		pwdata = 32'h0;
		pin = 4'h0;
		{n_fail, tests_run, t0} = {32'd0, 32'd0, 32'd0};
		do_rst(1'b1);
		rc("count", CA, 8'h00);
		rc("ictl", IA, 8'h00);
		rc("option a", OA, 8'hff);
		rc("option b", OB, 8'hff);
		chk("pullup", {31'h0, pullup_disable}, 32'h1);
		wr(CB, 8'h5a);
		rc("count mirror", CA, 8'h5a);
		xfer(1'b1, 12'h804, 32'h99);
		rc("count kept", CB, 8'h5a);
		foreach (w[i]) begin
			// indexes 1c2h..1dfh hold no register, unlike the low window
			xfer(1'b0, (i < 2) ? 12'h801 + 12'(i) : 12'h700 + 12'(i * 4), 32'h0);
			chk("unmapped", v, 32'h0);
		end
		wr(IC, 8'h78);
		rc("ictl a", IA, 8'h78);
		rc("ictl b", IB, 8'h78);
		rc("ictl d", ID, 8'h78);
		wr(OB, 8'h38);
		rc("option mirror", OA, 8'h38);
		chk("pullup", {31'h0, pullup_disable}, 32'h0);
		for (int r = 0; r < 8; r++) begin
			wr(OA, {5'b11000, r[2:0]});
			rc("rate read", OB, {5'b11000, r[2:0]});
			w = v;
			xfer(1'b0, {1'b0, CA, 2'b00}, 32'h0);
			w = v;
			repeat ((8 << r) - 3) @(posedge clk_sys);
			xfer(1'b0, {1'b0, CA, 2'b00}, 32'h0);
			chk("timer rate", (v - w) & 32'hff, 32'h4);
			wr(CA, 8'h00);
			wr(OA, {5'b11001, r[2:0]});
			t0 = ticks;
			rise(tmr_pkg::PIN_WDOG, 2 << r);
			repeat (8) @(posedge clk_sys);
			chk("watchdog rate", 32'(ticks - t0), 32'h2);
		end
		wr(OA, 8'hc0);
		t0 = ticks;
		rise(tmr_pkg::PIN_WDOG, 3);
		repeat (8) @(posedge clk_sys);
		chk("watchdog direct", 32'(ticks - t0), 32'h3);
		// external clock, rising edge, so overflow only moves with the test pin
		wr(CA, 8'h00);
		wr(OA, 8'he8);
		wr(IA, 8'h78);
		wr(ST, 8'h07);
		wr(MK, 8'h00);
		wr(CA, 8'hfe);
		rise(tmr_pkg::PIN_TCLK, 2);
		rise(tmr_pkg::PIN_EXT, 1);
		rise(tmr_pkg::PIN_PORT, 1);
		repeat (4) @(posedge clk_sys);
		rc("overflow count", CA, 8'h00);
		rc("event flags", IA, 8'h7f);
		rc("event status", ST, 8'h07);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(MK, 8'h04);
		// the write lands at the edge the task returns on; look once it has settled
		@(negedge clk_sys);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		wr(IA, 8'hff);
		@(negedge clk_sys);
		chk("cpu irq", {31'h0, cpu_irq}, 32'h1);
		wr(ST, 8'h07);
		rc("status cleared", ST, 8'h00);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		wr(CA, 8'h33);
		do_rst(1'b0);
		rc("warm count", CB, 8'h33);
		rc("warm ictl", IB, 8'h01);
		rc("warm option", OB, 8'hff);
		rc("warm mask", MK, 8'h00);
		do_rst(1'b1);
		rc("cold count", CA, 8'h00);
		rc("cold ictl", ID, 8'h00);
		end_sim();
	end
	initial begin
		#2ms;
		n_fail++;
		end_sim();
	end
endmodule
